//--- i2cis_core.v
// I2C-compatible controller with interrupt sequencing
`timescale 1ns/1ns
`default_nettype none
`include "i2cis_consts.vh"
module i2cis_core (
	// Clocking
	input wire core_clk,
	input wire nrst,
	input wire ce,
	// Bus pins, open drain
	input wire scl_in,
	output wire scl_out,
	output wire scl_oe,
	input wire sda_in,
	output wire sda_out,
	output wire sda_oe,
	// Firmware control write
	input wire ctl_wr,
	input wire ctl_ack,
	input wire ctl_xmit,
	input wire ctl_role,
	input wire ctl_proceed,
	input wire data_wr,
	input wire [7:0] data_in,
	// Interrupt
	input wire irq_en,
	input wire irq_service,
	output wire irq,
	// Status
	output wire [7:0] data_out,
	output wire ack_bit,
	output wire xmit_mode,
	output wire controller_role_bit,
	output wire busy,
	output wire addr_flag,
	output wire stop_flag,
	output wire arbitration_lost_restart_flag
);
	localparam [7:0] S_IDLE = 8'h01;
	localparam [7:0] S_SBIT = 8'h02;
	localparam [7:0] S_SACK = 8'h04;
	localparam [7:0] S_WAIT = 8'h08;
	localparam [7:0] S_MSTART = 8'h10;
	localparam [7:0] S_MBIT = 8'h20;
	localparam [7:0] S_MSTOP = 8'h40;
	localparam [7:0] S_ARBW = 8'h80;
	localparam [8:0] HALF = `I2CIS_HALF_CYC;
	localparam [8:0] SETUP = `I2CIS_SDA_SETUP_CYC;

	wire [1:0] pins_s;
	reg scl_prev_reg, sda_prev_reg;
	reg [7:0] st_reg;
	reg [7:0] sh_reg, tx_reg, rd_reg;
	reg [3:0] cnt_reg;
	reg [8:0] tmr_reg;
	reg [1:0] ph_reg, kind_reg, wk_reg;
	reg scl_drv_reg, sda_drv_reg, stx_reg;
	reg first_reg, slv_act_reg, bus_busy_reg;
	reg pend_reg, addr_reg, stop_reg, arb_reg;
	reg ack_reg, xmit_reg, role_reg, proceed_reg;

	i2cis_sync #(.W(2)) u_sync (
		.core_clk(core_clk),
		.nrst(nrst),
		.ce(ce),
		.d({scl_in, sda_in}),
		.q(pins_s)
	);

	wire scl_s = pins_s[1];
	wire sda_s = pins_s[0];
	wire scl_rise = scl_s & ~scl_prev_reg;
	wire scl_fall = ~scl_s & scl_prev_reg;
	wire start_det = scl_s & scl_prev_reg & ~sda_s & sda_prev_reg;
	wire stop_det = scl_s & scl_prev_reg & sda_s & ~sda_prev_reg;
	wire master_st = |(st_reg & (S_MSTART | S_MBIT | S_MSTOP));
	wire [3:0] endc = (kind_reg == `I2CIS_KIND_TX) ? 4'h9 :
		(kind_reg == `I2CIS_KIND_RX) ? 4'h8 : 4'h1;
	wire tmr_done = (tmr_reg == HALF);

	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oe = scl_drv_reg;
	assign sda_oe = sda_drv_reg;
	assign irq = pend_reg & irq_en;
	assign data_out = rd_reg;
	assign ack_bit = ack_reg;
	assign xmit_mode = xmit_reg;
	assign controller_role_bit = role_reg;
	assign busy = proceed_reg;
	assign addr_flag = addr_reg;
	assign stop_flag = stop_reg;
	assign arbitration_lost_restart_flag = arb_reg;

	always @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
			st_reg <= `I2CIS_STATE_RESET;
			sh_reg <= 8'h00;
			tx_reg <= 8'h00;
			rd_reg <= 8'h00;
			cnt_reg <= 4'h0;
			tmr_reg <= 9'h000;
			ph_reg <= 2'h0;
			kind_reg <= `I2CIS_KIND_TX;
			wk_reg <= `I2CIS_WK_SRX;
			scl_drv_reg <= 1'b0;
			sda_drv_reg <= 1'b0;
			stx_reg <= 1'b0;
			first_reg <= 1'b0;
			slv_act_reg <= 1'b0;
			bus_busy_reg <= 1'b0;
			pend_reg <= 1'b0;
			addr_reg <= 1'b0;
			stop_reg <= 1'b0;
			arb_reg <= 1'b0;
			ack_reg <= 1'b0;
			xmit_reg <= 1'b0;
			role_reg <= 1'b0;
			proceed_reg <= 1'b0;
		end
		else if (ce)
		begin
			scl_prev_reg <= scl_s;
			sda_prev_reg <= sda_s;
			if (start_det)
				bus_busy_reg <= 1'b1;
			if (stop_det)
				bus_busy_reg <= 1'b0;
			// Service clears; any set below in this edge wins
			if (irq_service)
			begin
				pend_reg <= 1'b0;
				arb_reg <= 1'b0;
				stop_reg <= 1'b0;
			end
			if (data_wr)
				tx_reg <= data_in;
			if (ctl_wr)
			begin
				ack_reg <= ctl_ack;
				xmit_reg <= ctl_xmit;
				role_reg <= ctl_role;
				proceed_reg <= ctl_proceed;
			end
			if (master_st)
				tmr_reg <= tmr_done ? 9'h000 : tmr_reg + 9'h001;
			// Slave side follows an external master
			if (!master_st && st_reg != S_ARBW)
			begin
				if (start_det)
				begin
					st_reg <= S_SBIT;
					first_reg <= 1'b1;
					slv_act_reg <= 1'b1;
					stx_reg <= 1'b0;
					cnt_reg <= 4'h0;
					scl_drv_reg <= 1'b0;
					sda_drv_reg <= 1'b0;
				end
				else if (stop_det && slv_act_reg)
				begin
					st_reg <= S_IDLE;
					slv_act_reg <= 1'b0;
					stop_reg <= 1'b1;
					pend_reg <= 1'b1;
					proceed_reg <= 1'b0;
					scl_drv_reg <= 1'b0;
					sda_drv_reg <= 1'b0;
				end
			end
			case (st_reg)
			S_IDLE:
			begin
				// Master start once firmware asks and bus is free
				if (role_reg && proceed_reg && !bus_busy_reg && !start_det)
				begin
					st_reg <= S_MSTART;
					sda_drv_reg <= 1'b1;
					tmr_reg <= 9'h000;
				end
			end
			S_SBIT:
			begin
				if (scl_rise)
				begin
					cnt_reg <= cnt_reg + 4'h1;
					if (!stx_reg && cnt_reg < 4'h8)
						sh_reg <= {sh_reg[6:0], sda_s};
					if (stx_reg && cnt_reg == 4'h8)
						ack_reg <= ~sda_s;
				end
				else if (scl_fall)
				begin
					if (!stx_reg && cnt_reg == 4'h8)
					begin
						rd_reg <= sh_reg;
						addr_reg <= first_reg;
						first_reg <= 1'b0;
						wk_reg <= `I2CIS_WK_SRX;
						pend_reg <= 1'b1;
						proceed_reg <= 1'b0;
						scl_drv_reg <= 1'b1;
						st_reg <= S_WAIT;
					end
					else if (stx_reg && cnt_reg == 4'h9)
					begin
						wk_reg <= `I2CIS_WK_STX;
						pend_reg <= 1'b1;
						proceed_reg <= 1'b0;
						scl_drv_reg <= 1'b1;
						st_reg <= S_WAIT;
					end
					else if (stx_reg)
					begin
						sh_reg <= {sh_reg[6:0], 1'b0};
						sda_drv_reg <= (cnt_reg < 4'h8) & ~sh_reg[6];
					end
				end
			end
			S_SACK:
			begin
				if (scl_fall)
				begin
					cnt_reg <= 4'h0;
					sda_drv_reg <= 1'b0;
					if (!ack_reg)
					begin
						// Refused byte: drop out, no stop detection
						st_reg <= S_IDLE;
						slv_act_reg <= 1'b0;
					end
					else
					begin
						st_reg <= S_SBIT;
						stx_reg <= xmit_reg;
						sh_reg <= tx_reg;
						sda_drv_reg <= xmit_reg & ~tx_reg[7];
					end
				end
			end
			S_WAIT:
			begin
				if (proceed_reg && !(ctl_wr && !ctl_proceed))
				begin
					case (wk_reg)
					`I2CIS_WK_SRX:
					begin
						st_reg <= S_SACK;
						sda_drv_reg <= ack_reg;
						scl_drv_reg <= 1'b0;
					end
					`I2CIS_WK_STX:
					begin
						scl_drv_reg <= 1'b0;
						cnt_reg <= 4'h0;
						sh_reg <= tx_reg;
						stx_reg <= 1'b1;
						st_reg <= xmit_reg ? S_SBIT : S_IDLE;
						sda_drv_reg <= xmit_reg & ~tx_reg[7];
					end
					`I2CIS_WK_MTX:
					begin
						tmr_reg <= 9'h000;
						ph_reg <= 2'h0;
						cnt_reg <= 4'h0;
						sh_reg <= tx_reg;
						kind_reg <= xmit_reg ? `I2CIS_KIND_TX :
							`I2CIS_KIND_RX;
						st_reg <= role_reg ? S_MBIT : S_MSTOP;
					end
					default:
					begin
						tmr_reg <= 9'h000;
						ph_reg <= 2'h0;
						cnt_reg <= 4'h0;
						kind_reg <= `I2CIS_KIND_ACK;
						st_reg <= S_MBIT;
					end
					endcase
				end
			end
			S_MSTART:
			begin
				if (tmr_done)
				begin
					st_reg <= S_MBIT;
					scl_drv_reg <= 1'b1;
					ph_reg <= 2'h0;
					cnt_reg <= 4'h0;
					kind_reg <= `I2CIS_KIND_TX;
					sh_reg <= tx_reg;
				end
			end
			S_MBIT:
			begin
				if (ph_reg == 2'h0)
				begin
					scl_drv_reg <= 1'b1;
					if (tmr_reg == SETUP)
					begin
						if (kind_reg == `I2CIS_KIND_TX)
							sda_drv_reg <= (cnt_reg < 4'h8) & ~sh_reg[7];
						else if (kind_reg == `I2CIS_KIND_ACK)
							sda_drv_reg <= ack_reg;
						else
							sda_drv_reg <= 1'b0;
					end
					if (tmr_done)
					begin
						ph_reg <= 2'h1;
						scl_drv_reg <= 1'b0;
					end
				end
				else if (!scl_s)
					tmr_reg <= 9'h000; // Slave stretching the clock
				else if (tmr_done)
				begin
					cnt_reg <= cnt_reg + 4'h1;
					ph_reg <= 2'h0;
					scl_drv_reg <= 1'b1;
					if (kind_reg == `I2CIS_KIND_RX)
						sh_reg <= {sh_reg[6:0], sda_s};
					else
						sh_reg <= {sh_reg[6:0], 1'b0};
					if (kind_reg == `I2CIS_KIND_TX && cnt_reg == 4'h8)
						ack_reg <= ~sda_s;
					if (kind_reg == `I2CIS_KIND_TX && cnt_reg < 4'h8 &&
						!sda_drv_reg && !sda_s)
					begin
						role_reg <= 1'b0;
						arb_reg <= 1'b1;
						scl_drv_reg <= 1'b0;
						st_reg <= S_ARBW;
					end
					else if (cnt_reg + 4'h1 == endc)
					begin
						tmr_reg <= 9'h000;
						cnt_reg <= 4'h0;
						if (kind_reg == `I2CIS_KIND_ACK)
						begin
							// Next byte or stop as set with the ack
							sh_reg <= tx_reg;
							kind_reg <= xmit_reg ? `I2CIS_KIND_TX :
								`I2CIS_KIND_RX;
							st_reg <= role_reg ? S_MBIT : S_MSTOP;
						end
						else
						begin
							if (kind_reg == `I2CIS_KIND_RX)
								rd_reg <= {sh_reg[6:0], sda_s};
							wk_reg <= (kind_reg == `I2CIS_KIND_TX) ?
								`I2CIS_WK_MTX : `I2CIS_WK_MRX;
							pend_reg <= 1'b1;
							proceed_reg <= 1'b0;
							sda_drv_reg <= 1'b0;
							st_reg <= S_WAIT;
						end
					end
				end
			end
			S_MSTOP:
			begin
				if (ph_reg == 2'h0)
				begin
					scl_drv_reg <= 1'b1;
					if (tmr_reg == SETUP)
						sda_drv_reg <= 1'b1;
					if (tmr_done)
					begin
						ph_reg <= 2'h1;
						scl_drv_reg <= 1'b0;
					end
				end
				else if (ph_reg == 2'h1)
				begin
					if (!scl_s)
						tmr_reg <= 9'h000;
					else if (tmr_done)
					begin
						sda_drv_reg <= 1'b0;
						ph_reg <= 2'h2;
					end
				end
				else if (tmr_done)
				begin
					ph_reg <= 2'h0;
					st_reg <= S_IDLE;
				end
			end
			S_ARBW:
			begin
				sda_drv_reg <= 1'b0;
				scl_drv_reg <= 1'b0;
				if (stop_det)
				begin
					pend_reg <= 1'b1;
					st_reg <= S_IDLE;
				end
			end
			default:
				st_reg <= S_IDLE;
			endcase
		end
	end
endmodule // i2cis_core
`default_nettype wire

//--- i2cis_consts.vh
// Constants for the I2C-compatible interrupt sequencer
`ifndef I2CIS_CONSTS_VH
`define I2CIS_CONSTS_VH
`define I2CIS_CLK_MHZ 50
`define I2CIS_HALF_NS 5000
// Half bit in core cycles, sized to the timer so nothing is cut
`define I2CIS_HALF_CYC 9'h0FA
`define I2CIS_SDA_SETUP_CYC 9'h001
`define I2CIS_KIND_TX 2'h0
`define I2CIS_KIND_RX 2'h1
`define I2CIS_KIND_ACK 2'h2
`define I2CIS_WK_SRX 2'h0
`define I2CIS_WK_STX 2'h1
`define I2CIS_WK_MTX 2'h2
`define I2CIS_WK_MRX 2'h3
`define I2CIS_STATE_RESET 8'h01
`endif

//--- i2cis_sync.v
// Two-stage synchroniser for bus pins
`timescale 1ns/1ns
`default_nettype none
module i2cis_sync #(
	parameter W = 2
) (
	// Clocking
	input wire core_clk,
	input wire nrst,
	input wire ce,
	// Data
	input wire [W-1:0] d,
	output reg [W-1:0] q
);
	reg [W-1:0] meta_reg;

	always @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			meta_reg <= {W{1'b1}};
			q <= {W{1'b1}};
		end
		else if (ce)
		begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule // i2cis_sync
`default_nettype wire

//--- i2cis_props.sv
// Port checker for the interrupt sequencer
`timescale 1ns/1ns
`default_nettype none
module i2cis_props (
	// Watched ports
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic irq_en,
	input wire logic irq_service,
	input wire logic ctl_wr,
	input wire logic ctl_ack,
	input wire logic irq,
	input wire logic busy,
	input wire logic scl_oe,
	input wire logic ack_bit,
	input wire logic [7:0] data_out,
	input wire logic addr_flag,
	input wire logic stop_flag,
	input wire logic controller_role_bit,
	input wire logic arbitration_lost_restart_flag
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!nrst);
	a_irq_gated: assert property (irq |-> irq_en)
		else $error("irq while disabled");
	a_busy_clear: assert property ($rose(irq) |-> !busy)
		else $error("busy set at interrupt");
	a_wait_hold: assert property (irq && !stop_flag
		&& !arbitration_lost_restart_flag && !ctl_wr |=> scl_oe)
		else $error("bus left wait without proceed");
	a_status_stable: assert property (irq && !ctl_wr && !irq_service
		|=> $stable(data_out) && $stable(addr_flag))
		else $error("status moved while pending");
	a_pending_kept: assert property ($fell(irq)
		|-> !irq_en || $past(irq_service))
		else $error("pending interrupt lost");
	a_stop_irq: assert property ($rose(stop_flag) && irq_en |-> irq)
		else $error("stop without interrupt");
	a_ack_write: assert property (ctl_wr |=> ack_bit == $past(ctl_ack))
		else $error("ack bit not written");
	a_arb_role: assert property ($rose(arbitration_lost_restart_flag)
		|-> !controller_role_bit)
		else $error("role kept after arbitration loss");
endmodule // i2cis_props
bind i2cis_core i2cis_props i_props (
	.core_clk(core_clk), .nrst(nrst), .irq_en(irq_en),
	.irq_service(irq_service), .ctl_wr(ctl_wr), .ctl_ack(ctl_ack),
	.irq(irq), .busy(busy), .scl_oe(scl_oe), .ack_bit(ack_bit),
	.data_out(data_out), .addr_flag(addr_flag), .stop_flag(stop_flag),
	.controller_role_bit(controller_role_bit),
	.arbitration_lost_restart_flag(arbitration_lost_restart_flag)
);
`default_nettype wire

//--- i2cis_bus_model.sv
// Behavioural far side of the bus: external master and slave
`timescale 1ns/1ns
`default_nettype none
module i2cis_bus_model (
	// Pacing and bus wires
	input wire logic core_clk,
	input wire logic scl,
	input wire logic sda,
	output logic scl_low,
	output logic sda_low
);
	// Four cycles low and four high: a 160 ns bus clock
	localparam int HALF = 3;
	initial
	begin
		scl_low = 1'b0;
		sda_low = 1'b0;
	end
	task automatic hw();
		repeat (HALF) @(negedge core_clk);
	endtask
	// Slave may stretch the released clock
	task automatic rise();
	begin
		scl_low = 1'b0;
		do @(negedge core_clk); while (scl !== 1'b1);
	end
	endtask
	task automatic start();
	begin
		sda_low = 1'b1;
		hw();
		scl_low = 1'b1;
	end
	endtask
	task automatic send(input logic [7:0] b);
	begin
		for (int i = 7; i >= 0; i--)
		begin
			@(negedge core_clk);
			sda_low = ~b[i];
			hw();
			rise();
			hw();
			scl_low = 1'b1;
		end
	end
	endtask
	task automatic ack_clk(output logic a);
	begin
		@(negedge core_clk);
		sda_low = 1'b0;
		hw();
		rise();
		hw();
		a = ~sda;
		scl_low = 1'b1;
	end
	endtask
	// Read a byte from the block, then answer on the ninth clock
	task automatic recv(output logic [7:0] b, input logic ak);
	begin
		for (int i = 7; i >= 0; i--)
		begin
			@(negedge core_clk);
			sda_low = 1'b0;
			hw();
			rise();
			hw();
			b[i] = sda;
			scl_low = 1'b1;
		end
		@(negedge core_clk);
		sda_low = ak;
		hw();
		rise();
		hw();
		scl_low = 1'b1;
	end
	endtask
	// Slave for the block as master: take a byte and acknowledge it
	task automatic take(output logic [7:0] b);
	begin
		for (int i = 7; i >= 0; i--)
		begin
			@(posedge scl);
			b[i] = sda;
		end
		@(negedge scl);
		sda_low = 1'b1;
		@(negedge scl);
		sda_low = 1'b0;
	end
	endtask
	// Slave answer to a master read; data changes only while clock low
	task automatic give(input logic [7:0] v);
	begin
		for (int i = 7; i >= 0; i--)
		begin
			sda_low = ~v[i];
			@(negedge scl);
		end
		sda_low = 1'b0;
	end
	endtask
	task automatic stop();
	begin
		@(negedge core_clk);
		sda_low = 1'b1;
		hw();
		rise();
		hw();
		sda_low = 1'b0;
		hw();
	end
	endtask
endmodule // i2cis_bus_model
`default_nettype wire

//--- tb.sv
// Self-checking bench for the interrupt sequencer
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic core_clk, nrst, ce, ctl_wr, ctl_ack, ctl_xmit, ctl_role;
	logic ctl_proceed, data_wr, irq_en, irq_service, a;
	logic [7:0] data_in;
	logic [31:0] lfsr;
	logic [7:0] q[$];
	int mismatches, n_checks;
	wire scl_oe, sda_oe, irq, busy, addr_flag, stop_flag, ack_bit;
	wire m_scl, m_sda, role, xmode;
	wire [7:0] data_out;
	wire scl = ~(scl_oe | m_scl);
	wire sda = ~(sda_oe | m_sda);
	i2cis_core i_dut (
		.core_clk(core_clk), .nrst(nrst), .ce(ce), .scl_in(scl),
		.scl_out(), .scl_oe(scl_oe), .sda_in(sda), .sda_out(),
		.sda_oe(sda_oe), .ctl_wr(ctl_wr), .ctl_ack(ctl_ack),
		.ctl_xmit(ctl_xmit), .ctl_role(ctl_role),
		.ctl_proceed(ctl_proceed), .data_wr(data_wr), .data_in(data_in),
		.irq_en(irq_en), .irq_service(irq_service), .irq(irq),
		.data_out(data_out), .ack_bit(ack_bit), .xmit_mode(xmode),
		.controller_role_bit(role), .busy(busy), .addr_flag(addr_flag),
		.stop_flag(stop_flag), .arbitration_lost_restart_flag()
	);
	i2cis_bus_model i_mst (
		.core_clk(core_clk), .scl(scl), .sda(sda),
		.scl_low(m_scl), .sda_low(m_sda)
	);
	function automatic logic [31:0] nx(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic chk(input logic ok, input string m);
	begin
		n_checks++;
		if (ok !== 1'b1)
		begin
			mismatches++;
			$display("[FAIL] %0t %s", $time, m);
		end
	end
	endtask
	task automatic final_report();
	begin
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	end
	endtask
	task automatic wirq();
	int i;
	begin
		for (i = 0; i < 4000 && irq !== 1'b1; i++)
			@(negedge core_clk);
		chk(irq === 1'b1, "no interrupt");
	end
	endtask
	// Service, load data, then one proceed write
	task automatic ctl(input logic ack, input logic xm, input logic rl);
	begin
		@(negedge core_clk);
		irq_service = 1'b1;
		data_in = lfsr[15:8];
		data_wr = 1'b1;
		@(negedge core_clk);
		irq_service = 1'b0;
		data_wr = 1'b0;
		chk(irq === 1'b0, "not serviced");
		ctl_ack = ack;
		ctl_xmit = xm;
		ctl_role = rl;
		ctl_proceed = 1'b1;
		ctl_wr = 1'b1;
		@(negedge core_clk);
		ctl_wr = 1'b0;
	end
	endtask
	task automatic xfer(input logic ack);
	logic [7:0] b;
	begin
		i_mst.start();
		for (int k = 0; k < (ack ? 2 : 1); k++)
		begin
			lfsr = nx(lfsr);
			q.push_back(lfsr[7:0]);
			i_mst.send(lfsr[7:0]);
			if (irq_en)
				wirq();
			else
			begin
				repeat (80) @(negedge core_clk);
				chk(irq === 1'b0, "masked irq seen");
				irq_en = 1'b1;
				@(negedge core_clk);
				chk(irq === 1'b1, "pending lost");
			end
			b = q.pop_front();
			chk(data_out === b, "rx byte");
			chk(addr_flag === (k == 0), "addr flag");
			chk(busy === 1'b0 && scl_oe === 1'b1, "no wait");
			ctl(ack, 1'b0, 1'b0);
			i_mst.ack_clk(a);
			chk(a === ack, "ack level");
		end
		i_mst.stop();
		if (ack)
			wirq();
		else
			repeat (80) @(negedge core_clk);
		chk(stop_flag === ack && irq === ack, "stop flag");
		@(negedge core_clk);
		irq_service = 1'b1;
		@(negedge core_clk);
		irq_service = 1'b0;
		@(negedge core_clk);
		chk(stop_flag === 1'b0 && irq === 1'b0, "stop kept");
	end
	endtask
	// Slave transmit: address in, two bytes out, the last one refused
	task automatic stx_scn();
	logic [7:0] b, e;
	begin
		i_mst.start();
		i_mst.send(8'hA5);
		wirq();
		for (int k = 0; k < 2; k++)
		begin
			lfsr = nx(lfsr);
			e = lfsr[15:8];
			ctl(1'b1, 1'b1, 1'b0);
			chk(xmode === 1'b1, "xmit mode");
			if (k == 0)
			begin
				i_mst.ack_clk(a);
				chk(a === 1'b1, "addr ack");
			end
			i_mst.recv(b, k == 0);
			wirq();
			chk(b === e, "tx byte");
			chk(ack_bit === (k == 0), "master ack");
			chk(busy === 1'b0 && scl_oe === 1'b1, "tx wait");
		end
		ctl(1'b0, 1'b0, 1'b0);
		i_mst.stop();
		wirq();
		@(negedge core_clk);
		irq_service = 1'b1;
		@(negedge core_clk);
		irq_service = 1'b0;
	end
	endtask
	// Master: address out, one byte in, refused, then stop
	task automatic mst_scn();
	logic [7:0] b, e, v;
	begin
		lfsr = nx(lfsr);
		e = lfsr[15:8];
		ctl(1'b0, 1'b1, 1'b1);
		i_mst.take(b);
		wirq();
		chk(b === e, "address byte");
		chk(ack_bit === 1'b1 && role === 1'b1, "slave ack");
		chk(busy === 1'b0 && scl_oe === 1'b1, "mtx wait");
		v = lfsr[7:0];
		fork
			i_mst.give(v);
			ctl(1'b0, 1'b0, 1'b1);
		join
		wirq();
		chk(data_out === v, "master rx byte");
		chk(busy === 1'b0 && scl_oe === 1'b1, "mrx wait");
		ctl(1'b0, 1'b0, 1'b0);
		repeat (1600) @(negedge core_clk);
		chk(role === 1'b0 && scl === 1'b1 && sda === 1'b1, "no stop");
	end
	endtask
	initial
	begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	initial
	begin
		#1000000;
		mismatches++;
		final_report();
	end
	initial
	begin
		{nrst, ctl_wr, ctl_ack, ctl_xmit, ctl_role} = 5'h00;
		{ctl_proceed, data_wr, irq_en, irq_service} = 4'h0;
		ce = 1'b1;
		data_in = 8'h00;
		lfsr = 32'h87C6;
		repeat (8) @(negedge core_clk);
		nrst = 1'b1;
		xfer(1'b1);
		xfer(1'b0);
		xfer(1'b1);
		stx_scn();
		mst_scn();
		final_report();
	end
endmodule // tb
`default_nettype wire
